//--- common/alm_map.svh
`ifndef ALM_MAP_SVH
`define ALM_MAP_SVH

// register offsets on the internal register access port
`define ALM_OFS_LOOP_STATUS   8'h00
`define ALM_OFS_LOOP_EVENTS   8'h01
`define ALM_OFS_UNLOCK_COUNT  8'h02
`define ALM_OFS_SPARE_CONFIG  8'h03
`define ALM_OFS_SPARE_STATUS  8'h04

// field positions
`define ALM_BIT_LOCK          0
`define ALM_BIT_RAIL_HIGH     3
`define ALM_BIT_RAIL_LOW      2
`define ALM_BIT_LOL_LMT       1
`define ALM_BIT_LOL           0
`define ALM_BIT_REG_DIS       15
`define ALM_BIT_SENSE_SEL     13
`define ALM_BIT_GATE_BYPASS   12
`define ALM_BIT_GATE_START    11
`define ALM_LSB_LDO_BYPASS    4
`define ALM_MSB_LDO_BYPASS    10

// reset values
`define ALM_RST_EVENTS        4'h0
`define ALM_RST_COUNT         4'h0
`define ALM_RST_CONFIG        16'h0000
`define ALM_RST_SPARE_STS     16'h0000

// counter limits
`define ALM_COUNT_MAX         4'hF
`define ALM_COUNT_CLEAR       4'h0

`endif

//--- common/alm_pkg.sv
`default_nettype none

package alm_pkg;

  // event register, bits 3..0
  typedef struct packed {
    logic rail_high;
    logic rail_low;
    logic lol_lmt;
    logic lol;
  } alm_evt_t;

  // spare configuration word, bits 15..0
  typedef struct packed {
    logic       reg_dis;
    logic       spare;
    logic       sense_sel;
    logic       gate_bypass;
    logic       gate_start;
    logic [6:0] ldo_bypass;
    logic [3:0] trim;
  } alm_cfg_t;

  // one access from the serial slave port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } alm_req_t;

  typedef enum logic [0:0] {
    ALM_GATE_IDLE,
    ALM_GATE_WAIT
  } alm_gate_t;

endpackage : alm_pkg

`default_nettype wire

//--- core/alm_sync3.sv
`timescale 1ns/1ns
`default_nettype none

module alm_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             srst,
  // asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & q);
    end
  end

endmodule : alm_sync3

`default_nettype wire

//--- core/alm_regs.sv
// Behaviour
// - lock status bit zero reads live lock
// - rail-high detection sets event bit three
// - rail-low detection sets event bit two
// - rail flags stay set until written one
// - counter above threshold sets event bit one
// - clear of bit one fails while exceeding
// - lock falling edge sets event bit zero
// - unlock counter counts falls, saturates at fifteen
// - write zero clears counter, other values preset
// - gate start waits for non-floating supplies
// - gate bypass skips the supply wait
// - regulator disable bit fifteen, reset zero
// - per-bank regulator bypass bits ten to four
// - four-bit trim drives bandgap trim input
`timescale 1ns/1ns
`default_nettype none
`include "alm_map.svh"

module alm_regs
  import alm_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // register access from the serial slave port
  input  wire alm_req_t    req,
  output var  logic [15:0] rdata_q,
  // analog loop lock detector, asynchronous
  input  wire logic        loop_locked,
  input  wire logic        rail_high,
  input  wire logic        rail_low,
  input  wire logic [15:0] spare_status,
  // loss-of-lock threshold from its own register
  input  wire logic [3:0]  lol_threshold,
  // output supply presence, asynchronous, and floating marks
  input  wire logic [6:0]  supply_present,
  input  wire logic [6:0]  supply_floating,
  // configuration load sequencing
  input  wire logic        load_req,
  output var  logic        load_go_q,
  output var  logic        load_waiting_q,
  // analog configuration
  output var  alm_cfg_t    cfg_q
);

  localparam int SYNC_W = 3 + 16 + 7;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic              lock_s;
  logic              rail_high_s;
  logic              rail_low_s;
  logic [15:0]       spare_s;
  logic [6:0]        supply_s;
  logic              lock_prev_q;
  logic              lock_fall;
  alm_evt_t          evt_q;
  logic [3:0]        cnt_q;
  logic              over_thr;
  logic              wr_evt;
  logic              wr_cnt;
  logic              wr_cfg;
  logic [3:0]        clr_mask;
  logic              supplies_ok;
  alm_gate_t         gate_q;

  assign sync_in = {loop_locked, rail_high, rail_low, spare_status,
                    supply_present};

  alm_sync3 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        (sync_in),
    .q        (sync_out)
  );

  assign lock_s      = sync_out[SYNC_W-1];
  assign rail_high_s = sync_out[SYNC_W-2];
  assign rail_low_s  = sync_out[SYNC_W-3];
  assign spare_s     = sync_out[22:7];
  assign supply_s    = sync_out[6:0];

  function automatic logic wr_hit(alm_req_t r, logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction : wr_hit

  assign wr_evt   = wr_hit(req, `ALM_OFS_LOOP_EVENTS);
  assign wr_cnt   = wr_hit(req, `ALM_OFS_UNLOCK_COUNT);
  assign wr_cfg   = wr_hit(req, `ALM_OFS_SPARE_CONFIG);
  assign clr_mask = wr_evt ? req.wdata[3:0] : 4'h0;

  // lock edge detection on the filtered level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lock_prev_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_s;
    end
  end

  assign lock_fall = lock_prev_q && !lock_s;
  assign over_thr  = cnt_q > lol_threshold;

  // event flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      evt_q <= `ALM_RST_EVENTS;
    end else begin
      evt_q.rail_high <= rail_high_s ||
        (evt_q.rail_high && !clr_mask[`ALM_BIT_RAIL_HIGH]);
      evt_q.rail_low  <= rail_low_s ||
        (evt_q.rail_low && !clr_mask[`ALM_BIT_RAIL_LOW]);
      evt_q.lol_lmt   <= over_thr ||
        (evt_q.lol_lmt && !clr_mask[`ALM_BIT_LOL_LMT]);
      evt_q.lol       <= lock_fall ||
        (evt_q.lol && !clr_mask[`ALM_BIT_LOL]);
    end
  end

  // unlock counter: a write loads, a fall in the same cycle still counts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_q <= `ALM_RST_COUNT;
    end else begin
      if (wr_cnt) begin
        if (lock_fall && req.wdata[3:0] != `ALM_COUNT_MAX) begin
          cnt_q <= req.wdata[3:0] + 4'h1;
        end else begin
          cnt_q <= req.wdata[3:0];
        end
      end else if (lock_fall && cnt_q != `ALM_COUNT_MAX) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // configuration word, every bit stored as written
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= `ALM_RST_CONFIG;
    end else if (wr_cfg) begin
      cfg_q <= alm_cfg_t'(req.wdata);
    end
  end

  // register read, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      if (req.addr == `ALM_OFS_LOOP_STATUS) begin
        rdata_q <= {15'h0000, lock_s};
      end else if (req.addr == `ALM_OFS_LOOP_EVENTS) begin
        rdata_q <= {12'h000, evt_q};
      end else if (req.addr == `ALM_OFS_UNLOCK_COUNT) begin
        rdata_q <= {12'h000, cnt_q};
      end else if (req.addr == `ALM_OFS_SPARE_CONFIG) begin
        rdata_q <= cfg_q;
      end else if (req.addr == `ALM_OFS_SPARE_STATUS) begin
        rdata_q <= spare_s;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  // every supply either present or marked floating
  assign supplies_ok = &(supply_s | supply_floating);

  // configuration load gating; sense_sel is stored only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      gate_q    <= ALM_GATE_IDLE;
      load_go_q <= 1'b0;
    end else begin
      load_go_q <= 1'b0;
      case (gate_q)
        ALM_GATE_IDLE: begin
          if (load_req) begin
            if (cfg_q.gate_start && !cfg_q.gate_bypass
                && !supplies_ok) begin
              gate_q <= ALM_GATE_WAIT;
            end else begin
              load_go_q <= 1'b1;
            end
          end
        end
        ALM_GATE_WAIT: begin
          if (cfg_q.gate_bypass || supplies_ok) begin
            gate_q    <= ALM_GATE_IDLE;
            load_go_q <= 1'b1;
          end
        end
        default: begin
          gate_q <= ALM_GATE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_waiting_q <= 1'b0;
    end else begin
      load_waiting_q <= (gate_q == ALM_GATE_WAIT) && !load_go_q;
    end
  end

  // ---- checks ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_rd(logic [7:0] ofs);
    req.rd && req.addr == ofs;
  endsequence

  sequence s_clr(int b);
    wr_evt && req.wdata[b];
  endsequence

  sequence s_fall_free;
    lock_fall && !wr_cnt;
  endsequence

  sequence s_keep(int b);
    !(wr_evt && req.wdata[b]);
  endsequence

  a_lock_read: assert property (
    s_rd(`ALM_OFS_LOOP_STATUS) |=> rdata_q == {15'h0000, $past(lock_s)})
    else $error("lock status read wrong");

  a_rail_high_set: assert property (
    rail_high_s |=> evt_q.rail_high)
    else $error("rail high flag not set");

  a_rail_low_set: assert property (
    rail_low_s |=> evt_q.rail_low)
    else $error("rail low flag not set");

  a_rail_hold: assert property (
    evt_q.rail_high ##0 s_keep(`ALM_BIT_RAIL_HIGH) |=> evt_q.rail_high)
    else $error("rail high flag dropped");

  a_rail_clear: assert property (
    evt_q.rail_low ##0 s_clr(`ALM_BIT_RAIL_LOW) ##0 !rail_low_s
    |=> !evt_q.rail_low)
    else $error("rail low flag not cleared");

  a_limit_set: assert property (
    over_thr |=> evt_q.lol_lmt)
    else $error("threshold flag not set");

  a_limit_sticky: assert property (
    s_clr(`ALM_BIT_LOL_LMT) ##0 over_thr |=> evt_q.lol_lmt)
    else $error("threshold flag cleared while exceeding");

  a_lol_set: assert property (
    lock_prev_q && !lock_s |=> evt_q.lol)
    else $error("loss of lock flag not set");

  a_count_step: assert property (
    s_fall_free ##0 cnt_q != `ALM_COUNT_MAX
    |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("unlock count did not step");

  a_count_sat: assert property (
    cnt_q == `ALM_COUNT_MAX && !wr_cnt |=> cnt_q == `ALM_COUNT_MAX)
    else $error("unlock count wrapped");

  a_count_load: assert property (
    wr_cnt && !lock_fall |=> cnt_q == $past(req.wdata[3:0]))
    else $error("unlock count preset lost");

  a_gate_wait: assert property (
    gate_q == ALM_GATE_WAIT && !cfg_q.gate_bypass && !supplies_ok
    |=> !load_go_q && gate_q == ALM_GATE_WAIT)
    else $error("load started without supplies");

  a_gate_bypass: assert property (
    gate_q == ALM_GATE_IDLE && load_req && cfg_q.gate_bypass
    |=> load_go_q ##1 !load_go_q)
    else $error("bypass did not load at once");

  a_cfg_write: assert property (
    wr_cfg |=> cfg_q == $past(req.wdata) ##1
      (cfg_q == $past(cfg_q) || $past(wr_cfg)))
    else $error("configuration write lost");

  a_zero_write: assert property (
    wr_evt && req.wdata[3:0] == 4'h0 |=>
      (evt_q & $past(evt_q)) == $past(evt_q))
    else $error("zero write cleared a flag");

  a_rail_low_hold: assert property (
    evt_q.rail_low ##0 s_keep(`ALM_BIT_RAIL_LOW) |=> evt_q.rail_low)
    else $error("rail low flag dropped");

  a_limit_hold: assert property (
    evt_q.lol_lmt ##0 s_keep(`ALM_BIT_LOL_LMT) |=> evt_q.lol_lmt)
    else $error("threshold flag dropped");

  a_lol_hold: assert property (
    evt_q.lol ##0 s_keep(`ALM_BIT_LOL) |=> evt_q.lol)
    else $error("loss of lock flag dropped");

  a_evt_read: assert property (
    s_rd(`ALM_OFS_LOOP_EVENTS) |=> rdata_q == {12'h000, $past(evt_q)})
    else $error("event read wrong");

  a_count_read: assert property (
    s_rd(`ALM_OFS_UNLOCK_COUNT) |=> rdata_q == {12'h000, $past(cnt_q)})
    else $error("unlock count read wrong");

  a_cfg_read: assert property (
    s_rd(`ALM_OFS_SPARE_CONFIG) |=> rdata_q == $past(cfg_q))
    else $error("configuration read wrong");

  a_spare_read: assert property (
    s_rd(`ALM_OFS_SPARE_STATUS) |=> rdata_q == $past(spare_s))
    else $error("spare status read wrong");

  a_hole_read: assert property (
    req.rd && req.addr > `ALM_OFS_SPARE_STATUS |=> rdata_q == 16'h0000)
    else $error("unmapped read not zero");

  a_cfg_keep: assert property (
    !wr_cfg |=> cfg_q == $past(cfg_q))
    else $error("configuration changed without write");

  a_wait_flag: assert property (
    gate_q == ALM_GATE_WAIT && !load_go_q |=> load_waiting_q)
    else $error("waiting flag missing");

endmodule : alm_regs

`default_nettype wire

//--- tb/apll_lock_monitor_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "alm_map.svh"

module apll_lock_monitor_regs_bench
  import alm_pkg::*;
();
  logic        core_clk;
  logic        srst;
  alm_req_t    req;
  logic [15:0] rdata_q;
  logic        loop_locked;
  logic        rail_high;
  logic        rail_low;
  logic [15:0] spare_status;
  logic [3:0]  lol_threshold;
  logic [6:0]  supply_present;
  logic [6:0]  supply_floating;
  logic        load_req;
  logic        load_go_q;
  logic        load_waiting_q;
  alm_cfg_t    cfg_q;
  int          bad_count;
  int          tests_run;
  int          m_cnt;
  int          m_evt;
  int          n;
  logic [31:0] seed;
  logic [15:0] d;

  alm_regs dut (
    .core_clk(core_clk), .srst(srst), .req(req), .rdata_q(rdata_q),
    .loop_locked(loop_locked), .rail_high(rail_high),
    .rail_low(rail_low), .spare_status(spare_status),
    .lol_threshold(lol_threshold), .supply_present(supply_present),
    .supply_floating(supply_floating), .load_req(load_req),
    .load_go_q(load_go_q), .load_waiting_q(load_waiting_q),
    .cfg_q(cfg_q)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask : tick

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
    req <= '{1'b1, 1'b0, a, v};
    tick(1);
    req <= '0;
    tick(1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    req <= '{1'b0, 1'b1, a, 16'h0000};
    tick(1);
    req <= '0;
    chk(rdata_q, exp, $sformatf("read %h", a));
    tick(1);
  endtask : reg_rd

  // one lock period followed by one loss of lock, model updated
  task automatic fall();
    loop_locked <= 1'b1;
    tick(8);
    reg_rd(`ALM_OFS_LOOP_STATUS, 16'h0001);
    loop_locked <= 1'b0;
    tick(8);
    reg_rd(`ALM_OFS_LOOP_STATUS, 16'h0000);
    m_cnt = (m_cnt < 15) ? m_cnt + 1 : 15;
    m_evt |= 1;
    if (m_cnt > lol_threshold) m_evt |= 2;
  endtask : fall

  task automatic wait_go();
    n = 0;
    while (load_go_q !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
  endtask : wait_go

  initial begin
    #(100 * 4000);
    bad_count++;
    complete_run();
  end

  initial begin
    srst = 1'b1;
    req = '0;
    loop_locked = 1'b0;
    rail_high = 1'b0;
    rail_low = 1'b0;
    spare_status = 16'h0000;
    lol_threshold = 4'h3;
    supply_present = 7'h00;
    supply_floating = 7'h00;
    load_req = 1'b0;
    bad_count = 0;
    tests_run = 0;
    m_cnt = 0;
    m_evt = 0;
    seed = 32'h102FE49F;
    tick(20);
    srst <= 1'b0;
    tick(1);
    for (int a = 0; a < 6; a++) reg_rd(a[7:0], 16'h0000);
    chk(cfg_q, `ALM_RST_CONFIG, "cfg_q");
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = seed[15:0] & 16'hDFFF;
      spare_status <= seed[31:16];
      reg_wr(`ALM_OFS_SPARE_CONFIG, d);
      chk(cfg_q, d, "cfg_q");
      reg_rd(`ALM_OFS_SPARE_CONFIG, d);
      reg_wr(`ALM_OFS_SPARE_STATUS, ~d);
      reg_wr(`ALM_OFS_LOOP_STATUS, 16'hFFFF);
      reg_rd(`ALM_OFS_SPARE_STATUS, seed[31:16]);
      reg_rd(`ALM_OFS_LOOP_STATUS, 16'h0000);
    end
    $display("test config done");

    for (int i = 0; i < 17; i++) begin
      fall();
      reg_rd(`ALM_OFS_UNLOCK_COUNT, m_cnt[15:0]);
      reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
    end
    reg_wr(`ALM_OFS_LOOP_EVENTS, 16'h0002);
    reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
    reg_wr(`ALM_OFS_UNLOCK_COUNT, 16'h0000);
    m_cnt = 0;
    reg_rd(`ALM_OFS_UNLOCK_COUNT, 16'h0000);
    reg_wr(`ALM_OFS_LOOP_EVENTS, 16'h0000);
    reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
    reg_wr(`ALM_OFS_LOOP_EVENTS, 16'hFFF3);
    m_evt = 0;
    reg_rd(`ALM_OFS_LOOP_EVENTS, 16'h0000);
    reg_wr(`ALM_OFS_UNLOCK_COUNT, 16'hFFF5);
    m_cnt = 5;
    reg_rd(`ALM_OFS_UNLOCK_COUNT, 16'h0005);
    fall();
    reg_rd(`ALM_OFS_UNLOCK_COUNT, m_cnt[15:0]);
    reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
    $display("test unlock done");

    lol_threshold <= 4'hF;
    for (int b = 2; b < 4; b++) begin
      if (b == 3) rail_high <= 1'b1;
      else rail_low <= 1'b1;
      tick(8);
      m_evt |= 1 << b;
      reg_wr(`ALM_OFS_LOOP_EVENTS, 16'(1 << b));
      reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
      rail_high <= 1'b0;
      rail_low <= 1'b0;
      tick(8);
      reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
      reg_wr(`ALM_OFS_LOOP_EVENTS, 16'h0000);
      reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
      reg_wr(`ALM_OFS_LOOP_EVENTS, 16'(1 << b));
      m_evt &= ~(1 << b);
      reg_rd(`ALM_OFS_LOOP_EVENTS, m_evt[15:0]);
    end
    $display("test rail done");

    reg_wr(`ALM_OFS_SPARE_CONFIG, 16'h0800);
    supply_present <= 7'h0F;
    supply_floating <= 7'h30;
    tick(6);
    load_req <= 1'b1;
    tick(1);
    load_req <= 1'b0;
    tick(3);
    chk({15'h0000, load_waiting_q}, 16'h0001, "waiting");
    chk({15'h0000, load_go_q}, 16'h0000, "go early");
    supply_floating <= 7'h70;
    wait_go();
    chk({15'h0000, n < 3}, 16'h0001, "go after supplies");
    tick(2);
    supply_present <= 7'h00;
    supply_floating <= 7'h00;
    for (int k = 0; k < 2; k++) begin
      reg_wr(`ALM_OFS_SPARE_CONFIG, k ? 16'h1800 : 16'h0000);
      load_req <= 1'b1;
      tick(1);
      load_req <= 1'b0;
      wait_go();
      chk({15'h0000, n < 2}, 16'h0001, "go prompt");
      chk({15'h0000, load_waiting_q}, 16'h0000, "no wait");
      tick(2);
    end
    $display("test gating done");
    complete_run();
  end
endmodule : apll_lock_monitor_regs_bench

`default_nettype wire
